// [design/pst_params.svh]
// Purpose: constants for policer and router-leg statistics
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: event bit order is fixed by the event builders in pst_stats
`ifndef PST_PARAMS_SVH
`define PST_PARAMS_SVH
`define PST_CNT_W 40
`define PST_LOW_W 32
`define PST_HIGH_W 8
`define PST_LEN_W 14
`define PST_EVT_W 8
`define PST_TTL_W 8
`define PST_TTL_MIN 8'h02
`define PST_POL_TYPES 2
`define PST_LEG_TYPES 8
`define PST_IPV_NUM 2
`define PST_BANKS 5
`define PST_BANK_RG_LSB 2
`define PST_CFG_NUM 22
`define PST_CFG_BYTE_BIT 8
`define PST_CFG_MASK_RST 8'h00
`define PST_WORD_BYTES 4
`define PST_CNT_BYTES 8
`define PST_HI_BIT 2
`define PST_BDL_BASE 16'h1000
`define PST_FLD_BASE 16'h2000
`define PST_ACL_BASE 16'h3000
`define PST_ING_BASE 16'h4000
`define PST_EGR_BASE 16'h8000
`define PST_MASK_BDL 8'h07
`define PST_MASK_FLD 8'h3F
`define PST_MASK_ACL 8'hFF
`define PST_MASK_ING 8'h7F
`define PST_MASK_EGR 8'h1F
`endif

// [design/pst_pkg.sv]
// Purpose: shared types of the statistics block
// Assumes: pst_params.svh holds the numbers
// Notes: region codes are one-hot
`include "pst_params.svh"
package pst_pkg;
	typedef logic [`PST_CNT_W-1:0] pst_cnt_t;
	typedef enum logic [6:0] {
		PST_RG_NONE = 7'h01,
		PST_RG_CFG = 7'h02,
		PST_RG_BDL = 7'h04,
		PST_RG_FLD = 7'h08,
		PST_RG_ACL = 7'h10,
		PST_RG_ING = 7'h20,
		PST_RG_EGR = 7'h40
	} pst_region_e;
	typedef struct packed {
		pst_region_e region;
		logic [10:0] idx;
		logic hi;
	} pst_dec_s;
	typedef enum logic [1:0] {PST_FR_BC = 2'h0, PST_FR_MC = 2'h1, PST_FR_UC = 2'h2} pst_kind_e;
	typedef enum logic [1:0] {PST_CLR_GREEN = 2'h0, PST_CLR_YELLOW = 2'h1, PST_CLR_RED = 2'h2} pst_color_e;
endpackage

// [design/pst_bank_if.sv]
// Purpose: link between the register side and one counter bank
// Assumes: one clock
// Notes: rd_data is combinational from the bank array
`include "pst_params.svh"
`timescale 1ns/100ps
`default_nettype none
interface pst_bank_if #(parameter int IW = 5, parameter int TYPES = 2);
	logic upd;
	logic [IW-1:0] set_idx;
	logic [TYPES-1:0] hit;
	logic [TYPES-1:0] byte_mode;
	logic [`PST_LEN_W-1:0] len;
	logic wr_en;
	logic [IW-1:0] wr_idx;
	logic [IW-1:0] rd_idx;
	pst_pkg::pst_cnt_t wr_data;
	pst_pkg::pst_cnt_t rd_data;
	modport stat (output upd, set_idx, hit, byte_mode, len, wr_en, wr_idx, rd_idx, wr_data, input rd_data);
	modport bank (input upd, set_idx, hit, byte_mode, len, wr_en, wr_idx, rd_idx, wr_data, output rd_data);
endinterface
`default_nettype wire

// [design/pst_bank.sv]
// Purpose: one bank of 40-bit counters, TYPES per counter set
// Assumes: at most one set updated per cycle
// Notes: a software load wins over a same-cycle count
`include "pst_params.svh"
`timescale 1ns/100ps
`default_nettype none
module pst_bank #(
	parameter int DEPTH = 32,
	parameter int TYPES = 2
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	pst_bank_if.bank bus
);
	localparam int IW = $clog2(DEPTH);
	pst_pkg::pst_cnt_t mem_reg [0:DEPTH-1];
	pst_pkg::pst_cnt_t old0;
	pst_pkg::pst_cnt_t inc0;
	logic [IW-1:0] e0;

	function automatic int entry(input logic [IW-1:0] set, input int t);
		return int'(set) * TYPES + t;
	endfunction

	function automatic pst_pkg::pst_cnt_t step(input logic byte_mode, input logic [`PST_LEN_W-1:0] len);
		return byte_mode ? `PST_CNT_W'(len) : `PST_CNT_W'(1);
	endfunction

	if (DEPTH < 2 || TYPES < 1 || DEPTH % TYPES != 0)
	begin : g_bad
		$error("pst_bank: unsupported geometry");
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_reg[i] <= '0;
		end
		else
		begin
			for (int t = 0; t < TYPES; t++)
			begin
				if (bus.upd && bus.hit[t] && entry(bus.set_idx, t) < DEPTH)
					mem_reg[IW'(entry(bus.set_idx, t))] <=
						mem_reg[IW'(entry(bus.set_idx, t))] + step(bus.byte_mode[t], bus.len);
			end
			if (bus.wr_en)
				mem_reg[bus.wr_idx] <= bus.wr_data;
		end
	end

	assign bus.rd_data = mem_reg[bus.rd_idx];

	assign e0 = IW'(entry(bus.set_idx, 0));
	assign old0 = mem_reg[e0];
	assign inc0 = step(bus.byte_mode[0], bus.len);

	a_bank_add: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		bus.upd && bus.hit[0] && !bus.wr_en && entry(bus.set_idx, 0) < DEPTH
		|=> mem_reg[$past(e0)] == $past(old0) + $past(inc0))
		else $error("counter did not add bytes or one");

	a_bank_load: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		bus.wr_en |=> mem_reg[$past(bus.wr_idx)] == $past(bus.wr_data))
		else $error("counter load lost");
endmodule // pst_bank
`default_nettype wire

// [design/pst_stats.sv]
// Purpose: policer and router-leg statistics with APB access
// Assumes: one 40 MHz clock; event inputs come from same-clock logic
// Notes: zero-wait APB; read data and error are taken at setup
//
// Implementation choices: the APB interface to the registers and the address map.
`include "pst_params.svh"
`timescale 1ns/100ps
`default_nettype none
module pst_stats #(
	parameter int NUM_BDL = 16,
	parameter int NUM_FLD = 16,
	parameter int NUM_ACL = 16,
	parameter int NUM_LEG = 64
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [15:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [`PST_LEN_W-1:0] frame_len_i,
	input wire logic bdl_hit_i,
	input wire logic [$clog2(NUM_BDL)-1:0] bdl_idx_i,
	input wire pst_pkg::pst_color_e bdl_color_i,
	input wire logic fld_hit_i,
	input wire logic [$clog2(NUM_FLD)-1:0] fld_idx_i,
	input wire pst_pkg::pst_kind_e fld_kind_i,
	input wire logic fld_discard_i,
	input wire logic acl_hit_i,
	input wire logic [$clog2(NUM_ACL)-1:0] acl_idx_i,
	input wire logic acl_from_cpu_i,
	input wire logic acl_by_second_stage_i,
	input wire logic acl_inner_policer_flag_i,
	input wire logic acl_discard_i,
	input wire logic ing_hit_i,
	input wire logic [$clog2(NUM_LEG)-1:0] ing_leg_i,
	input wire logic ing_ipv6_i,
	input wire logic ing_route_ok_i,
	input wire logic ing_lookup_discard_i,
	input wire logic ing_routing_permit_action_i,
	input wire logic ing_uc_rx_i,
	input wire logic ing_mc_rx_i,
	input wire logic ing_uc_routed_i,
	input wire logic ing_mc_routed_i,
	input wire logic ing_rpf_fail_i,
	input wire logic [`PST_TTL_W-1:0] ing_ttl_i,
	input wire logic egr_hit_i,
	input wire logic [$clog2(NUM_LEG)-1:0] egr_leg_i,
	input wire logic egr_ipv6_i,
	input wire logic egr_route_ok_i,
	input wire logic egr_lookup_discard_i,
	input wire logic egr_routing_permit_action_i,
	input wire logic egr_uc_routed_i,
	input wire logic egr_mc_routed_i,
	input wire logic egr_mc_switched_i,
	input wire logic [`PST_TTL_W-1:0] egr_ttl_i,
	input wire logic [`PST_TTL_W-1:0] egr_ttl_limit_i
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	function automatic int bank_depth(input int b);
		case (b)
			0: return NUM_BDL * `PST_POL_TYPES;
			1: return NUM_FLD * `PST_POL_TYPES;
			2: return NUM_ACL * `PST_POL_TYPES;
			default: return NUM_LEG * `PST_IPV_NUM * `PST_LEG_TYPES;
		endcase
	endfunction

	function automatic int bank_types(input int b);
		return (b < 3) ? `PST_POL_TYPES : `PST_LEG_TYPES;
	endfunction

	function automatic int cfg_base(input int b);
		return (b < 4) ? b * `PST_POL_TYPES : 3 * `PST_POL_TYPES + `PST_LEG_TYPES;
	endfunction

	function automatic logic [15:0] bank_base(input int b);
		case (b)
			0: return `PST_BDL_BASE;
			1: return `PST_FLD_BASE;
			2: return `PST_ACL_BASE;
			3: return `PST_ING_BASE;
			default: return `PST_EGR_BASE;
		endcase
	endfunction

	// which bank a configuration slot belongs to
	function automatic int set_of(input int k);
		int s;
		s = 4;
		for (int b = 3; b >= 0; b--)
			if (k < cfg_base(b + 1))
				s = b;
		return s;
	endfunction

	function automatic logic [`PST_EVT_W-1:0] valid_mask(input int k);
		case (set_of(k))
			0: return `PST_MASK_BDL;
			1: return `PST_MASK_FLD;
			2: return `PST_MASK_ACL;
			3: return `PST_MASK_ING;
			default: return `PST_MASK_EGR;
		endcase
	endfunction

	function automatic pst_pkg::pst_dec_s addr_decode(input logic [15:0] a);
		pst_pkg::pst_dec_s d;
		logic [15:0] off;
		d.region = pst_pkg::PST_RG_NONE;
		d.idx = 11'(a >> `PST_HI_BIT);
		d.hi = a[`PST_HI_BIT];
		off = '0;
		if (32'(a) < `PST_CFG_NUM * `PST_WORD_BYTES)
		begin
			d.region = pst_pkg::PST_RG_CFG;
			d.hi = 1'b0;
		end
		for (int b = 0; b < `PST_BANKS; b++)
		begin
			off = a - bank_base(b);
			if (a >= bank_base(b) && 32'(off) < bank_depth(b) * `PST_CNT_BYTES)
			begin
				d.region = pst_pkg::pst_region_e'(7'(1 << (b + `PST_BANK_RG_LSB)));
				d.idx = 11'(off >> ($clog2(`PST_CNT_BYTES)));
			end
		end
		return d;
	endfunction

	if (NUM_BDL < 2 || NUM_BDL > 256 || NUM_FLD < 2 || NUM_FLD > 256 ||
		NUM_ACL < 2 || NUM_ACL > 256 || NUM_LEG < 2 || NUM_LEG > 64)
	begin : g_bad
		$error("pst_stats: unsupported counter set count");
	end

	pst_pkg::pst_dec_s dec;
	logic setup;
	logic wr_acc;
	logic rd_setup;
	logic cnt_sel;
	logic [`PST_EVT_W-1:0] evt_bdl;
	logic [`PST_EVT_W-1:0] evt_fld;
	logic [`PST_EVT_W-1:0] evt_acl;
	logic [`PST_EVT_W-1:0] evt_ing;
	logic [`PST_EVT_W-1:0] evt_egr;
	logic acl_inner;
	logic [`PST_EVT_W-1:0] cfg_mask_reg [0:`PST_CFG_NUM-1];
	logic [`PST_CFG_NUM-1:0] cfg_byte_reg;
	logic [`PST_CFG_NUM-1:0] type_hit;
	logic [`PST_HIGH_W-1:0] shadow_reg;
	logic [`PST_HIGH_W-1:0] stage_reg;
	logic [`PST_BANKS-1:0] set_hit;
	logic [10:0] set_all [0:`PST_BANKS-1];
	pst_pkg::pst_cnt_t bank_rd [0:`PST_BANKS-1];
	pst_pkg::pst_cnt_t sel_cnt;
	logic [31:0] rd_word;
	logic [4:0] cfg_idx;

	assign dec = addr_decode(paddr_i);
	assign cfg_idx = dec.idx[4:0];
	assign setup = psel_i && !penable_i;
	assign wr_acc = psel_i && penable_i && pwrite_i;
	assign rd_setup = setup && !pwrite_i;
	assign cnt_sel = dec.region != pst_pkg::PST_RG_NONE && dec.region != pst_pkg::PST_RG_CFG;
	assign pready_o = 1'b1;

	// frame events, one bit per selectable class
	assign evt_bdl = {5'h00, bdl_color_i == pst_pkg::PST_CLR_RED, bdl_color_i == pst_pkg::PST_CLR_YELLOW,
		bdl_color_i == pst_pkg::PST_CLR_GREEN};
	assign evt_fld = {2'h0,
		!fld_discard_i && fld_kind_i == pst_pkg::PST_FR_UC,
		!fld_discard_i && fld_kind_i == pst_pkg::PST_FR_MC,
		!fld_discard_i && fld_kind_i == pst_pkg::PST_FR_BC,
		fld_discard_i && fld_kind_i == pst_pkg::PST_FR_UC,
		fld_discard_i && fld_kind_i == pst_pkg::PST_FR_MC,
		fld_discard_i && fld_kind_i == pst_pkg::PST_FR_BC};
	assign acl_inner = acl_by_second_stage_i && acl_inner_policer_flag_i;
	assign evt_acl = `PST_EVT_W'(1) << {acl_inner, acl_discard_i, !acl_from_cpu_i};
	assign evt_ing = {1'b0,
		ing_route_ok_i && ing_ttl_i < `PST_TTL_MIN,
		ing_rpf_fail_i,
		ing_mc_routed_i, ing_uc_routed_i, ing_mc_rx_i, ing_uc_rx_i,
		ing_route_ok_i && ing_lookup_discard_i && !ing_routing_permit_action_i};
	assign evt_egr = {3'h0,
		egr_route_ok_i && egr_ttl_i < egr_ttl_limit_i,
		egr_mc_switched_i, egr_mc_routed_i, egr_uc_routed_i,
		egr_route_ok_i && egr_lookup_discard_i && !egr_routing_permit_action_i};

	assign set_hit = {egr_hit_i, ing_hit_i, acl_hit_i, fld_hit_i, bdl_hit_i};
	assign set_all[0] = 11'(bdl_idx_i);
	assign set_all[1] = 11'(fld_idx_i);
	assign set_all[2] = 11'(acl_idx_i);
	assign set_all[3] = 11'({ing_leg_i, ing_ipv6_i});
	assign set_all[4] = 11'({egr_leg_i, egr_ipv6_i});

	// each counter type counts when its frame shows any class its mask enables
	for (genvar k = 0; k < `PST_CFG_NUM; k++)
	begin : g_type
		localparam int S = set_of(k);
		logic [`PST_EVT_W-1:0] evt;
		assign evt = (S == 0) ? evt_bdl : (S == 1) ? evt_fld : (S == 2) ? evt_acl : (S == 3) ? evt_ing : evt_egr;
		assign type_hit[k] = |(evt & cfg_mask_reg[k]);
	end

	for (genvar b = 0; b < `PST_BANKS; b++)
	begin : g_bank
		localparam int D = bank_depth(b);
		localparam int T = bank_types(b);
		localparam int W = $clog2(D);
		localparam int CB = cfg_base(b);
		pst_bank_if #(.IW(W), .TYPES(T)) bif ();
		assign bif.upd = set_hit[b];
		assign bif.set_idx = W'(set_all[b]);
		assign bif.hit = type_hit[CB +: T];
		assign bif.byte_mode = cfg_byte_reg[CB +: T];
		assign bif.len = frame_len_i;
		assign bif.wr_en = wr_acc && dec.region[b + `PST_BANK_RG_LSB] && !dec.hi;
		assign bif.wr_idx = W'(dec.idx);
		assign bif.rd_idx = W'(dec.idx);
		assign bif.wr_data = {stage_reg, pwdata_i};
		assign bank_rd[b] = bif.rd_data;
		pst_bank #(.DEPTH(D), .TYPES(T)) u_bank (
			.clk_i(clk_i),
			.rst_n_i(rst_n_i),
			.bus(bif.bank)
		);
	end

	always_comb
	begin
		sel_cnt = '0;
		rd_word = 32'h00000000;
		for (int b = 0; b < `PST_BANKS; b++)
			if (dec.region[b + `PST_BANK_RG_LSB])
				sel_cnt = bank_rd[b];
		if (dec.region == pst_pkg::PST_RG_CFG)
			rd_word = 32'({cfg_byte_reg[cfg_idx], cfg_mask_reg[cfg_idx]});
		else if (cnt_sel)
			rd_word = dec.hi ? 32'(shadow_reg) : sel_cnt[`PST_LOW_W-1:0];
	end

	// read data and error are settled at the setup edge and held through access
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prdata_o <= 32'h00000000;
			pslverr_o <= 1'b0;
		end
		else if (setup)
		begin
			prdata_o <= rd_word;
			pslverr_o <= dec.region == pst_pkg::PST_RG_NONE;
		end
	end

	// one shadow for all counters: the reader pairs low and high back to back
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			shadow_reg <= 8'h00;
		else if (rd_setup && cnt_sel && !dec.hi)
			shadow_reg <= sel_cnt[`PST_CNT_W-1:`PST_LOW_W];
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			stage_reg <= 8'h00;
		else if (wr_acc && cnt_sel && dec.hi)
			stage_reg <= pwdata_i[`PST_HIGH_W-1:0];
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cfg_byte_reg <= '0;
			for (int k = 0; k < `PST_CFG_NUM; k++)
				cfg_mask_reg[k] <= `PST_CFG_MASK_RST;
		end
		else if (wr_acc && dec.region == pst_pkg::PST_RG_CFG)
		begin
			cfg_mask_reg[cfg_idx] <= pwdata_i[`PST_EVT_W-1:0] & valid_mask(int'(cfg_idx));
			cfg_byte_reg[cfg_idx] <= pwdata_i[`PST_CFG_BYTE_BIT];
		end
	end

	a_shadow_latch: assert property (
		rd_setup && cnt_sel && !dec.hi |=> shadow_reg == $past(sel_cnt[`PST_CNT_W-1:`PST_LOW_W]))
		else $error("shadow not latched on low read");

	a_high_read: assert property (
		rd_setup && cnt_sel && dec.hi |=> prdata_o == 32'($past(shadow_reg)))
		else $error("high read not from shadow");

	a_low_read: assert property (
		rd_setup && cnt_sel && !dec.hi |=> prdata_o == $past(sel_cnt[`PST_LOW_W-1:0]))
		else $error("low read wrong");

	a_stage_high: assert property (
		wr_acc && cnt_sel && dec.hi |=> stage_reg == $past(pwdata_i[`PST_HIGH_W-1:0]))
		else $error("high write not staged");

	a_acl_outer: assert property (
		!(acl_by_second_stage_i && acl_inner_policer_flag_i) |-> evt_acl[7:4] == 4'h0)
		else $error("outer policer counted as inner");

	a_acl_class: assert property (
		$onehot(evt_acl) && evt_acl[{acl_inner, acl_discard_i, !acl_from_cpu_i}])
		else $error("access-list event wrong");

	a_flood_class: assert property (
		fld_kind_i != 2'h3 |-> $onehot(evt_fld) && (|evt_fld[5:3] == !fld_discard_i))
		else $error("flood class wrong");

	a_ing_acl: assert property (
		evt_ing[0] == (ing_route_ok_i && ing_lookup_discard_i && !ing_routing_permit_action_i))
		else $error("ingress acl discard wrong");

	a_ing_ttl: assert property (
		evt_ing[6] == (ing_route_ok_i && ing_ttl_i < `PST_TTL_MIN))
		else $error("ingress ttl discard wrong");

	a_egr_acl: assert property (
		evt_egr[0] == (egr_route_ok_i && egr_lookup_discard_i && !egr_routing_permit_action_i))
		else $error("egress acl discard wrong");

	a_egr_ttl: assert property (
		evt_egr[4] == (egr_route_ok_i && egr_ttl_i < egr_ttl_limit_i))
		else $error("egress ttl discard wrong");

	a_mask_gate: assert property (
		type_hit[0] |-> |(evt_bdl & cfg_mask_reg[0]) && evt_bdl[7:3] == 5'h00)
		else $error("bundle counter hit without mask");

	a_unmapped: assert property (
		setup && dec.region == pst_pkg::PST_RG_NONE |=> pslverr_o && prdata_o == 32'h00000000)
		else $error("unmapped access not refused");

	c_low_high: cover property (rd_setup && cnt_sel && !dec.hi ##2 rd_setup && cnt_sel && dec.hi);
	c_load: cover property (wr_acc && cnt_sel && dec.hi ##2 wr_acc && cnt_sel && !dec.hi);
	c_leg_hit: cover property (ing_hit_i && |type_hit[cfg_base(3) +: `PST_LEG_TYPES]);
	c_acl_inner: cover property (acl_hit_i && evt_acl[7] && type_hit[cfg_base(2)]);
endmodule // pst_stats
`default_nettype wire

// [verification/pst_frame_source.sv]
// Purpose: policer and routing pipeline model feeding per-frame events
// Assumes: one request at a time; pulses last one clock
// Notes: qualifiers carry fresh garbage whenever no frame is reported
`timescale 1ns/100ps
`default_nettype none
module pst_frame_source (
	input wire logic clk_i,
	output logic [4:0] hit_o,
	output logic [7:0] idx_o,
	output logic [15:0] qual_o,
	output logic [13:0] len_o
);
	logic go = 1'b0;
	logic [2:0] sel = 3'h0;
	logic [7:0] idx = 8'h00;
	logic [15:0] bits = 16'h0000;
	logic [13:0] len = 14'h0000;
	initial
	begin
		hit_o = 5'h00;
		idx_o = 8'h00;
		qual_o = 16'h0000;
		len_o = 14'h0000;
	end
	task automatic send(input logic [2:0] s, input logic [7:0] i, input logic [15:0] b, input logic [13:0] l);
		@(posedge clk_i);
		go <= 1'b1;
		sel <= s;
		idx <= i;
		bits <= b;
		len <= l;
		@(posedge clk_i);
		go <= 1'b0;
	endtask
	always @(posedge clk_i)
	begin
		hit_o <= go ? 5'(1 << sel) : 5'h00;
		idx_o <= go ? idx : 8'($urandom);
		qual_o <= go ? bits : 16'($urandom);
		len_o <= go ? len : 14'($urandom);
	end
endmodule // pst_frame_source
`default_nettype wire

// [verification/tb_pst_stats.sv]
// Purpose: self-checking bench for the statistics block over APB
// Assumes: four sets per policer bank, four router legs
// Notes: reads queue their expected word; a monitor compares at access
`include "pst_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_pst_stats;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [15:0] paddr_i = 16'h0000;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic [4:0] hv;
	logic [7:0] iv;
	logic [15:0] qv;
	logic [13:0] lv;
	logic [32:0] exp_q[$];
	int miscompares = 0;
	int checked = 0;
	logic [15:0] ib [0:8] = '{16'h8006, 16'h8010, 16'h8020, 16'h8040, 16'h8080, 16'h8100, 16'h0202, 16'h800E, 16'h0402};
	logic [15:0] eb [0:6] = '{16'h5506, 16'h5510, 16'h5520, 16'h5540, 16'h4502, 16'h550E, 16'h5502};
	always #12.5 clk_i = ~clk_i;
	pst_frame_source pst_frame_source_inst (.clk_i(clk_i), .hit_o(hv), .idx_o(iv), .qual_o(qv), .len_o(lv));
	pst_stats #(.NUM_BDL(4), .NUM_FLD(4), .NUM_ACL(4), .NUM_LEG(4)) pst_stats_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.frame_len_i(lv), .bdl_hit_i(hv[0]), .bdl_idx_i(iv[1:0]), .bdl_color_i(pst_pkg::pst_color_e'(qv[1:0])),
		.fld_hit_i(hv[1]), .fld_idx_i(iv[1:0]), .fld_kind_i(pst_pkg::pst_kind_e'(qv[1:0])), .fld_discard_i(qv[2]),
		.acl_hit_i(hv[2]), .acl_idx_i(iv[1:0]), .acl_from_cpu_i(qv[0]), .acl_by_second_stage_i(qv[1]),
		.acl_inner_policer_flag_i(qv[2]), .acl_discard_i(qv[3]),
		.ing_hit_i(hv[3]), .ing_leg_i(iv[1:0]), .ing_ipv6_i(qv[0]), .ing_route_ok_i(qv[1]),
		.ing_lookup_discard_i(qv[2]), .ing_routing_permit_action_i(qv[3]), .ing_uc_rx_i(qv[4]), .ing_mc_rx_i(qv[5]),
		.ing_uc_routed_i(qv[6]), .ing_mc_routed_i(qv[7]), .ing_rpf_fail_i(qv[8]), .ing_ttl_i({1'b0, qv[15:9]}),
		.egr_hit_i(hv[4]), .egr_leg_i(iv[1:0]), .egr_ipv6_i(qv[0]), .egr_route_ok_i(qv[1]),
		.egr_lookup_discard_i(qv[2]), .egr_routing_permit_action_i(qv[3]), .egr_uc_routed_i(qv[4]),
		.egr_mc_routed_i(qv[5]), .egr_mc_switched_i(qv[6]), .egr_ttl_i({4'h0, qv[15:12]}),
		.egr_ttl_limit_i({4'h0, qv[11:8]})
	);
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error %0t: read %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do
		begin
			@(posedge clk_i);
		end
		while (pready_o !== 1'b1);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic e, input logic [31:0] d);
		exp_q.push_back({e, d});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wr_cnt(input logic [15:0] a, input logic [39:0] v);
		apb(1'b1, a + 16'h4, {24'h0, v[39:32]});
		apb(1'b1, a, v[31:0]);
	endtask
	task automatic rd_cnt(input logic [15:0] a, input logic [39:0] v);
		rd(a, 1'b0, v[31:0]);
		rd(a + 16'h4, 1'b0, {24'h0, v[39:32]});
	endtask
	task automatic cfg(input int k, input logic [7:0] m, input logic b);
		apb(1'b1, 16'(4 * k), {23'h0, b, m});
	endtask
	function automatic logic [15:0] ca(input logic [15:0] base, input int set, input int types, input int t);
		return base + 16'(8 * (set * types + t));
	endfunction
	always @(posedge clk_i)
		if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && exp_q.size() > 0)
			check({pslverr_o, prdata_o}, exp_q.pop_front());
	initial
	begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		end_sim();
	end
	initial
	begin
		int k;
		int s;
		logic [39:0] r;
		logic [13:0] ln;
		logic [15:0] a;
		void'($urandom(32'h620d));
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(16'h0000, 1'b0, 32'h0);
		rd_cnt(`PST_EGR_BASE, 40'h0);
		rd(16'h0800, 1'b1, 32'h0);
		for (k = 0; k < 22; k++)
		begin
			apb(1'b1, 16'(4 * k), 32'hFFFFFFFF);
			rd(16'(4 * k), 1'b0, {23'h0, 1'b1, k < 2 ? `PST_MASK_BDL : k < 4 ? `PST_MASK_FLD : k < 6 ? `PST_MASK_ACL
				: k < 14 ? `PST_MASK_ING : `PST_MASK_EGR});
		end
		cfg(0, 8'h01, 1'b0);
		cfg(1, 8'h04, 1'b1);
		cfg(2, 8'h3F, 1'b0);
		cfg(3, 8'h08, 1'b0);
		cfg(4, 8'hF0, 1'b0);
		cfg(5, 8'h0F, 1'b0);
		for (k = 0; k < 8; k++)
			cfg(6 + k, k < 7 ? 8'(1 << k) : 8'h7F, k == 7);
		for (k = 0; k < 8; k++)
			cfg(14 + k, k < 5 ? 8'(1 << k) : k == 5 ? 8'h1F : 8'h00, k == 5);
		r = {$urandom, $urandom};
		wr_cnt(ca(`PST_ACL_BASE, 3, 2, 1), r);
		rd_cnt(ca(`PST_ACL_BASE, 3, 2, 1), r);
		a = ca(`PST_BDL_BASE, 1, 2, 0);
		wr_cnt(a, 40'h00_FFFFFFFF);
		rd(a, 1'b0, 32'hFFFFFFFF);
		pst_frame_source_inst.send(3'd0, 8'd1, 16'h0000, 14'd9);
		rd(a + 16'h4, 1'b0, 32'h0);
		rd_cnt(a, 40'h01_00000000);
		a = ca(`PST_BDL_BASE, 2, 2, 1);
		wr_cnt(a, 40'hFF_FFFFFFF0);
		pst_frame_source_inst.send(3'd0, 8'd2, 16'h0002, 14'd20);
		rd_cnt(a, 40'h4);
		ln = 14'($urandom_range(1, 16383));
		for (k = 0; k < 3; k++)
			pst_frame_source_inst.send(3'd0, 8'd0, 16'(k), ln);
		rd_cnt(ca(`PST_BDL_BASE, 0, 2, 0), 40'h1);
		rd_cnt(ca(`PST_BDL_BASE, 0, 2, 1), 40'(ln));
		for (k = 0; k < 8; k++)
			pst_frame_source_inst.send(3'd1, 8'd1, 16'(k), ln);
		rd_cnt(ca(`PST_FLD_BASE, 1, 2, 0), 40'h6);
		rd_cnt(ca(`PST_FLD_BASE, 1, 2, 1), 40'h1);
		for (k = 0; k < 8; k++)
			pst_frame_source_inst.send(3'd2, 8'd2, {12'h0, k[1], k[2], k[2], ~k[0]}, ln);
		pst_frame_source_inst.send(3'd2, 8'd2, 16'h000C, ln);
		pst_frame_source_inst.send(3'd2, 8'd2, 16'h0002, ln);
		rd_cnt(ca(`PST_ACL_BASE, 2, 2, 0), 40'h4);
		rd_cnt(ca(`PST_ACL_BASE, 2, 2, 1), 40'h6);
		s = $urandom_range(0, 7);
		for (k = 0; k < 9; k++)
			pst_frame_source_inst.send(3'd3, 8'(s >> 1), ib[k] | 16'(s & 1), ln);
		for (k = 0; k < 8; k++)
			rd_cnt(ca(`PST_ING_BASE, s, 8, k), k < 7 ? 40'h1 : 40'(ln) * 7);
		s = $urandom_range(0, 7);
		for (k = 0; k < 7; k++)
			pst_frame_source_inst.send(3'd4, 8'(s >> 1), eb[k] | 16'(s & 1), ln);
		for (k = 0; k < 8; k++)
			rd_cnt(ca(`PST_EGR_BASE, s, 8, k), k < 5 ? 40'h1 : k == 5 ? 40'(ln) * 5 : 40'h0);
		end_sim();
	end
endmodule // tb_pst_stats
`default_nettype wire
